// ===== logic/hpev_device.sv
/*
  Device end: processor port slave, event flags and control-cell mailbox.
  Assumes event inputs come from bus-side logic already in this clock domain.
*/
// Both port styles are implemented; the host style strap selects which one is used.
`timescale 1ns/100ps
`default_nettype none
module hpev_device import hpev_pkg::*; #(
  parameter int INLET_CELL_BYTES = INLET_CELL_BYTES_DEF,
  parameter int RX_CELLS = RX_FIFO_CELLS
) (
  input wire logic clk,
  input wire logic srst,
  hpev_if.dev port,
  input wire logic bip_err,
  input wire logic hdr_crc_err,
  input wire logic bus_frame_pulse,
  input wire logic bus_cycle_tick,
  input wire logic bus_rdclk_ok,
  input wire logic bus_wrclk_ok,
  input wire logic bus_req,
  input wire logic bus_grant,
  input wire logic oq_arrive,
  input wire logic [1:0] oq_class,
  input wire logic [6:0] oq_level,
  input wire logic phy_side_select,
  input wire logic link_mode,
  input wire logic inlet_cell_avail,
  input wire logic inlet_cell_start,
  input wire logic inlet_xfer_enable_n,
  input wire logic link_rx_valid,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  output logic tx_cell_send_request,
  input wire logic [5:0] tx_rd_addr,
  output logic [7:0] tx_rd_data,
  input wire logic tx_done,
  input wire logic tx_accepted,
  output logic online,
  output logic split_queue
);
  localparam int HW = $clog2(RX_CELLS);
  if (INLET_CELL_BYTES < 2 || INLET_CELL_BYTES > 255) begin : g_bad_len
    $error("inlet cell length unsupported");
  end
  if (RX_CELLS < 2 || (1 << HW) != RX_CELLS) begin : g_bad_depth
    $error("receive fifo depth must be a power of two");
  end

  hpev_dev_state_t state;
  logic [7:0] enable_a, enable_b, cell_ctrl, port_cfg, grant_timeout, cbr_len;
  logic [7:0] d_q;
  logic rd_q, irq_q;
  logic [7:0] status_a, status_b;
  logic [7:0] tx_buf [0:TX_CELL_BYTES-1];
  logic [7:0] rx_mem [0:RX_CELLS*RX_CELL_BYTES-1];
  logic [HW-1:0] rx_head, rx_tail;
  logic [HW:0] rx_cnt;
  logic [5:0] rx_idx;
  logic rx_drop;
  logic [3:0] frame_cyc;
  logic [2:0] miss_frames;
  logic [7:0] grant_wait;
  logic in_cell, avail_q;
  logic [7:0] inlet_cnt;

  // port decode for both host styles
  wire strap = port.host_style_strap;
  wire sel_act = !port.sel_n && (strap || !port.rd_n || !port.wr_n);
  wire is_wr = strap ? !port.rd_n : !port.wr_n;
  wire go = (state == HPEV_D_IDLE) && sel_act;
  wire go_wr = go && is_wr;
  wire go_rd = go && !is_wr;
  wire [7:0] a = port.addr;
  wire in_win = (a >= ADDR_RX_WIN) && (a <= ADDR_RX_WIN_END);
  wire in_tx = (a >= ADDR_TX_BUF) && (a <= ADDR_TX_BUF_END);
  wire [7:0] win_off = a - ADDR_RX_WIN;
  wire [7:0] tx_off = a - ADDR_TX_BUF;
  wire [7:0] win_byte = rx_mem[int'(rx_head) * RX_CELL_BYTES + int'(win_off)];
  wire [7:0] rd_val =
    (a == ADDR_STATUS_A) ? status_a :
    (a == ADDR_ENABLE_A) ? enable_a :
    (a == ADDR_STATUS_B) ? status_b :
    (a == ADDR_ENABLE_B) ? enable_b :
    (a == ADDR_CELL_CTRL) ? cell_ctrl :
    (a == ADDR_PORT_CFG) ? port_cfg :
    (a == ADDR_GRANT_TIMEOUT) ? grant_timeout :
    (a == ADDR_CBR_LEN) ? cbr_len :
    in_win ? win_byte :
    in_tx ? tx_buf[tx_off[5:0]] : 8'h00;
  wire clr_a = go_rd && (a == ADDR_STATUS_A);
  wire clr_b = go_rd && (a == ADDR_STATUS_B);

  always_ff @(posedge clk) begin
    if (srst) state <= HPEV_D_IDLE;
    else if (go) state <= HPEV_D_DONE;
    else if (port.sel_n) state <= HPEV_D_IDLE;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      d_q <= 8'h00;
      rd_q <= 1'b0;
    end else if (go) begin
      d_q <= rd_val;
      rd_q <= !is_wr;
    end
  end
  assign port.d_dev = d_q;
  assign port.d_dev_oe = (state == HPEV_D_DONE) && rd_q;
  // one stretched cycle per access; ready low or acknowledge withheld meanwhile
  assign port.ack_pin = strap ? (state != HPEV_D_DONE) : !(sel_act && state == HPEV_D_IDLE);
  assign port.irq_pin = strap ? !irq_q : irq_q;
  always_ff @(posedge clk) begin
    // enables gate flags directly, so masking needs no bus clock
    if (srst) irq_q <= 1'b0;
    else irq_q <= |(status_a & enable_a) || |(status_b & enable_b);
  end

  // plain registers
  always_ff @(posedge clk) begin
    if (srst) begin
      enable_a <= REG_RESET;
      enable_b <= REG_RESET;
      port_cfg <= REG_RESET;
      grant_timeout <= REG_RESET;
      cbr_len <= REG_RESET;
    end else if (go_wr) begin
      if (a == ADDR_ENABLE_A) enable_a <= port.data_bus;
      if (a == ADDR_ENABLE_B) enable_b <= port.data_bus;
      if (a == ADDR_PORT_CFG) port_cfg <= port.data_bus;
      if (a == ADDR_GRANT_TIMEOUT) grant_timeout <= port.data_bus;
      if (a == ADDR_CBR_LEN) cbr_len <= port.data_bus;
    end
  end
  assign online = port_cfg[BIT_ONLINE];
  assign split_queue = port_cfg[BIT_SPLIT_QUEUE];

  // mailbox handshake bits: host sets, device clears; a set beats a clear
  wire ctrl_wr = go_wr && (a == ADDR_CELL_CTRL);
  wire pop = cell_ctrl[BIT_RELEASE];
  always_ff @(posedge clk) begin
    if (srst) cell_ctrl <= CELL_CTRL_RESET;
    else begin
      if (ctrl_wr) cell_ctrl[7:2] <= port.data_bus[7:2];
      cell_ctrl[BIT_SEND_REQ] <= (ctrl_wr && port.data_bus[BIT_SEND_REQ])
                                 || (cell_ctrl[BIT_SEND_REQ] && !tx_done);
      cell_ctrl[BIT_RELEASE] <= ctrl_wr && port.data_bus[BIT_RELEASE];
    end
  end
  // online bit deliberately not consulted by the mailbox
  assign tx_cell_send_request = cell_ctrl[BIT_SEND_REQ];

  always_ff @(posedge clk) begin
    if (go_wr && in_tx) tx_buf[tx_off[5:0]] <= port.data_bus;
  end
  always_ff @(posedge clk) begin
    if (srst) tx_rd_data <= 8'h00;
    else tx_rd_data <= tx_buf[tx_rd_addr];
  end

  // receive fifo; head entry is the window the host reads
  wire rx_full = (rx_cnt == RX_CELLS[HW:0]);
  wire rx_first = rx_byte_valid && (rx_idx == 6'h00);
  wire drop_now = (rx_idx == 6'h00) ? rx_full : rx_drop;
  wire rx_last = rx_byte_valid && (rx_idx == 6'(RX_CELL_BYTES - 1));
  wire push = rx_last && !drop_now;
  wire do_pop = pop && (rx_cnt != '0);
  wire rx_ovf = rx_first && rx_full;
  // cell stays announced while one remains after this cycle's pop
  wire rx_ready = push || (do_pop ? (rx_cnt > (HW+1)'(1)) : (rx_cnt != '0));
  always_ff @(posedge clk) begin
    if (rx_byte_valid && !drop_now)
      rx_mem[int'(rx_tail) * RX_CELL_BYTES + int'(rx_idx)] <= rx_byte;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_idx <= 6'h00;
      rx_drop <= 1'b0;
      rx_head <= '0;
      rx_tail <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_byte_valid) rx_idx <= rx_last ? 6'h00 : rx_idx + 6'h01;
      if (rx_first) rx_drop <= rx_full;
      if (push) rx_tail <= rx_tail + 1'b1;
      if (do_pop) rx_head <= rx_head + 1'b1;
      rx_cnt <= rx_cnt + (HW+1)'(push) - (HW+1)'(do_pop);
    end
  end

  // bus frame supervision
  wire frame_end = bus_cycle_tick && (frame_cyc == 4'(FRAME_CYCLES - 1));
  wire lof = (miss_frames > 3'(LOF_FRAMES)) || !bus_wrclk_ok;
  wire [7:0] grant_next = grant_wait + 8'h01;
  wire grant_to = bus_req && !bus_grant && frame_end && (grant_timeout != 8'h00)
                  && (grant_next == grant_timeout);
  always_ff @(posedge clk) begin
    if (srst || bus_frame_pulse) begin
      frame_cyc <= 4'h0;
      miss_frames <= 3'h0;
    end else if (bus_cycle_tick) begin
      frame_cyc <= frame_cyc + 4'h1;
      if (frame_end && miss_frames <= 3'(LOF_FRAMES)) miss_frames <= miss_frames + 3'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || !bus_req || bus_grant) grant_wait <= 8'h00;
    else if (frame_end && grant_wait != 8'hFF) grant_wait <= grant_next;
  end

  // outlet overflow limits
  wire [6:0] vbr_limit = OQ_VBR_BASE - cbr_len[6:0];
  wire [6:0] class_limit =
    (oq_class == OQ_CLASS_CTL) ? OQ_CTL_LIMIT :
    (oq_class == OQ_CLASS_CBR) ? cbr_len[6:0] :
    (oq_class == OQ_CLASS_VBR) ? vbr_limit : OQ_ABR_LIMIT;
  wire [6:0] oq_limit = split_queue ? class_limit : OQ_SINGLE_LIMIT;
  wire oq_ovf = oq_arrive && (oq_level >= oq_limit);

  // inlet framing check
  wire beat = link_mode ? link_rx_valid : !inlet_xfer_enable_n;
  wire last_beat = beat && (inlet_cnt == 8'(INLET_CELL_BYTES - 1));
  wire next_in_cell = (link_mode && !link_rx_valid) ? 1'b0 : (last_beat ? 1'b0 : (beat || in_cell));
  wire atm_err = !link_mode && phy_side_select && ((inlet_cell_avail && !avail_q && !in_cell
                 && !inlet_cell_start) || (inlet_cell_start && in_cell));
  wire phy_err = !link_mode && !phy_side_select && ((beat && !in_cell && !inlet_cell_start)
                 || (inlet_cell_start && in_cell && beat));
  wire off_err = !link_mode && !phy_side_select && !online && beat && !in_cell;
  wire link_err = link_mode && in_cell && !link_rx_valid;
  always_ff @(posedge clk) begin
    if (srst) begin
      in_cell <= 1'b0;
      avail_q <= 1'b0;
      inlet_cnt <= 8'h00;
    end else begin
      in_cell <= next_in_cell;
      avail_q <= inlet_cell_avail;
      if (!next_in_cell) inlet_cnt <= 8'h00;
      else if (beat) inlet_cnt <= inlet_cnt + 8'h01;
    end
  end

  // event vectors
  logic [7:0] set_a, set_b, clr_evt_b;
  always_comb begin
    set_a = 8'h00;
    set_a[ST_A_REFUSED] = tx_done && !tx_accepted;
    set_a[ST_A_ACCEPTED] = tx_done && tx_accepted;
    set_a[ST_A_PARITY] = bip_err;
    set_a[ST_A_FRAME_LOST] = lof;
    set_a[ST_A_RDCLK_LOST] = !bus_rdclk_ok;
    set_a[ST_A_WRCLK_LOST] = !bus_wrclk_ok;
    set_b = 8'h00;
    set_b[ST_B_HDR_CRC] = hdr_crc_err;
    set_b[ST_B_RX_OVF] = rx_ovf;
    set_b[ST_B_RX_READY] = rx_ready;
    set_b[ST_B_FRAMING] = atm_err || phy_err || off_err || link_err;
    set_b[ST_B_SENT] = tx_done;
    set_b[ST_B_GRANT_TO] = grant_to;
    set_b[ST_B_OUTLET_OVF] = oq_ovf;
    clr_evt_b = 8'h00;
    clr_evt_b[ST_B_RX_READY] = do_pop;
  end

  hpev_evt_latch #(.N(8)) u_status_a (
    .clk(clk), .srst(srst), .set_evt(set_a), .clr_read(clr_a), .clr_evt(8'h00),
    .stat(status_a)
  );
  hpev_evt_latch #(.N(8)) u_status_b (
    .clk(clk), .srst(srst), .set_evt(set_b), .clr_read(clr_b), .clr_evt(clr_evt_b),
    .stat(status_b)
  );
endmodule : hpev_device
`default_nettype wire

// ===== pkg/hpev_pkg.sv
/*
  Shared constants and types for the host port, event flags and
  control-cell mailbox. Assumes one 25 MHz clock and a synchronous reset.
*/
// Notes on behaviour
// - strap low: separate strobes, high interrupt, ready
// - strap high: direction pin, low interrupt, acknowledge
// - thirteen latched events, enabled ones raise interrupt
// - status read clears bits unless condition persists
// - enable masking works without bus clocks
// - sent cell accepted or refused sets flag
// - parity byte mismatch sets parity flag
// - frame pulse missing over four frames
// - read and write clock loss flags
// - host resets device after bus clock loss
// - header check mismatch sets flag
// - cell arriving at full receive fifo
// - atm side: start missing or early
// - phy side: start missing or early
// - offline phy side arrival flags framing error
// - link mode: valid dropped mid cell
// - transmit buffer, send request, sent flag
// - grant missing for programmed frame count
// - outlet queue overflow limits per mode
// - receive window, release bit, next cell
// - receive ready and acknowledge interrupt enables
// - mailbox ignores online bit
package hpev_pkg;
  localparam logic [7:0] ADDR_STATUS_A = 8'h05;
  localparam logic [7:0] ADDR_ENABLE_A = 8'h06;
  localparam logic [7:0] ADDR_STATUS_B = 8'h08;
  localparam logic [7:0] ADDR_ENABLE_B = 8'h09;
  localparam logic [7:0] ADDR_CELL_CTRL = 8'h0A;
  localparam logic [7:0] ADDR_PORT_CFG = 8'h0C;
  localparam logic [7:0] ADDR_GRANT_TIMEOUT = 8'h0F;
  localparam logic [7:0] ADDR_CBR_LEN = 8'h10;
  localparam logic [7:0] ADDR_RX_WIN = 8'h60;
  localparam logic [7:0] ADDR_RX_WIN_END = 8'h93;
  localparam logic [7:0] ADDR_TX_BUF = 8'hA0;
  localparam logic [7:0] ADDR_TX_BUF_END = 8'hD7;
  localparam logic [7:0] CELL_CTRL_RESET = 8'h40;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int RX_CELL_BYTES = 52;
  localparam int TX_CELL_BYTES = 56;
  localparam int RX_FIFO_CELLS = 4;
  localparam int FRAME_CYCLES = 16;
  localparam int LOF_FRAMES = 4;
  localparam int INLET_CELL_BYTES_DEF = 53;
  localparam logic [6:0] OQ_SINGLE_LIMIT = 7'h7B;
  localparam logic [6:0] OQ_ABR_LIMIT = 7'h20;
  localparam logic [6:0] OQ_VBR_BASE = 7'h59;
  localparam logic [6:0] OQ_CTL_LIMIT = 7'h02;
  localparam logic [1:0] OQ_CLASS_CTL = 2'h0;
  localparam logic [1:0] OQ_CLASS_CBR = 2'h1;
  localparam logic [1:0] OQ_CLASS_VBR = 2'h2;
  localparam logic [1:0] OQ_CLASS_ABR = 2'h3;
  localparam int BIT_RELEASE = 0;
  localparam int BIT_SEND_REQ = 1;
  localparam int BIT_SPLIT_QUEUE = 2;
  localparam int BIT_ONLINE = 7;
  localparam int ST_A_REFUSED = 7;
  localparam int ST_A_ACCEPTED = 6;
  localparam int ST_A_PARITY = 5;
  localparam int ST_A_FRAME_LOST = 4;
  localparam int ST_A_RDCLK_LOST = 3;
  localparam int ST_A_WRCLK_LOST = 2;
  localparam int ST_B_HDR_CRC = 7;
  localparam int ST_B_RX_OVF = 6;
  localparam int ST_B_RX_READY = 5;
  localparam int ST_B_FRAMING = 4;
  localparam int ST_B_SENT = 3;
  localparam int ST_B_GRANT_TO = 2;
  localparam int ST_B_OUTLET_OVF = 0;
  typedef enum logic [1:0] {HPEV_D_IDLE = 2'b00, HPEV_D_DONE = 2'b01} hpev_dev_state_t;
  typedef enum logic [1:0] {
    HPEV_H_IDLE = 2'b00,
    HPEV_H_ACC = 2'b01,
    HPEV_H_REL = 2'b11
  } hpev_host_state_t;
endpackage : hpev_pkg

// ===== pkg/hpev_if.sv
/*
  Processor port pins between host controller and device.
  Assumes the testbench joins both ends; the shared data wire is resolved here.
*/
`timescale 1ns/100ps
`default_nettype none
interface hpev_if;
  logic host_style_strap;
  logic sel_n;
  logic rd_n;
  logic wr_n;
  logic [7:0] addr;
  logic [7:0] d_host;
  logic d_host_oe;
  logic [7:0] d_dev;
  logic d_dev_oe;
  logic irq_pin;
  logic ack_pin;
  logic [7:0] data_bus;
  // undriven bus floats high through the board pull-ups
  assign data_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hFF);
  modport dev(input host_style_strap, sel_n, rd_n, wr_n, addr, data_bus,
              output d_dev, d_dev_oe, irq_pin, ack_pin);
  modport host(output host_style_strap, sel_n, rd_n, wr_n, addr, d_host, d_host_oe,
               input data_bus, irq_pin, ack_pin);
endinterface : hpev_if
`default_nettype wire

// ===== logic/hpev_evt_latch.sv
/*
  Sticky event flags for one status register.
  Assumes set inputs are high while an event fires or its condition persists.
*/
`timescale 1ns/100ps
`default_nettype none
module hpev_evt_latch #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [N-1:0] set_evt,
  input wire logic clr_read,
  input wire logic [N-1:0] clr_evt,
  output logic [N-1:0] stat
);
  if (N < 1) begin : g_bad_width
    $error("hpev_evt_latch: N must be positive");
  end
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // one flop per bit keeps each process the sole writer of its variable
      logic q;
      always_ff @(posedge clk) begin
        if (srst) q <= 1'b0;
        else q <= set_evt[i] | (q & ~(clr_read | clr_evt[i]));
      end
      assign stat[i] = q;
    end
  endgenerate
endmodule : hpev_evt_latch
`default_nettype wire

// ===== logic/hpev_host.sv
/*
  Host end: drives the processor port pins for one access at a time.
  Assumes the user side waits while busy is high; strap set by parameter.
*/
`timescale 1ns/100ps
`default_nettype none
module hpev_host import hpev_pkg::*; #(
  parameter bit HOST_STYLE = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  hpev_if.host port,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic irq
);
  hpev_host_state_t state;
  logic is_rd;
  logic sel_n, rd_n, wr_n, oe;
  logic [7:0] addr, wdata;
  wire done = HOST_STYLE ? !port.ack_pin : port.ack_pin;
  wire start = (state == HPEV_H_IDLE) && (cmd_wr || cmd_rd);

  assign port.host_style_strap = HOST_STYLE;
  assign port.sel_n = sel_n;
  assign port.rd_n = rd_n;
  assign port.wr_n = wr_n;
  assign port.addr = addr;
  assign port.d_host = wdata;
  assign port.d_host_oe = oe;
  assign cmd_busy = (state != HPEV_H_IDLE);

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= HPEV_H_IDLE;
      sel_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      oe <= 1'b0;
      is_rd <= 1'b0;
      addr <= 8'h00;
      wdata <= 8'h00;
    end else begin
      case (state)
        HPEV_H_IDLE: begin
          if (start) begin
            state <= HPEV_H_ACC;
            sel_n <= 1'b0;
            is_rd <= cmd_rd;
            addr <= cmd_addr;
            wdata <= cmd_wdata;
            oe <= !cmd_rd;
            // second style: one direction pin, spare strobe held high
            rd_n <= HOST_STYLE ? cmd_rd : !cmd_rd;
            wr_n <= HOST_STYLE ? 1'b1 : cmd_rd;
          end
        end
        HPEV_H_ACC: begin
          // waits as long as the device stretches the access
          if (done) begin
            state <= HPEV_H_REL;
            sel_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            oe <= 1'b0;
          end
        end
        HPEV_H_REL: state <= HPEV_H_IDLE;
        default: state <= HPEV_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      irq <= 1'b0;
    end else begin
      rd_valid <= (state == HPEV_H_ACC) && done && is_rd;
      if ((state == HPEV_H_ACC) && done && is_rd) rd_data <= port.data_bus;
      irq <= HOST_STYLE ? !port.irq_pin : port.irq_pin;
    end
  end
endmodule : hpev_host
`default_nettype wire

// ===== verification/hpev_monitor.sv
/*
  Port-pin checker for the host/device processor port.
  Assumes it sits beside one interface and sees its pins as plain inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module hpev_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic host_style_strap,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic d_host_oe,
  input wire logic d_dev_oe,
  input wire logic ack_pin
);
  // direction and acknowledge sense differ between the two strap styles
  wire logic is_read = host_style_strap ? rd_n : !rd_n;
  wire logic ack_done = host_style_strap ? !ack_pin : ack_pin;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_start;
    $fell(sel_n);
  endsequence
  sequence s_answer;
    !ack_done ##1 ack_done;
  endsequence
  sequence s_span;
    !sel_n [*2] ##1 sel_n;
  endsequence
  a_no_bus_fight: assert property (!(d_dev_oe && d_host_oe))
    else $error("both ends drive the data bus");
  a_dev_after_sel: assert property (d_dev_oe |-> !$past(sel_n))
    else $error("device drives data outside an access");
  a_strobes_legal: assert property (host_style_strap ? wr_n : (rd_n || wr_n))
    else $error("strobe pins used against the selected host style");
  a_ack_answer: assert property (s_start |-> s_answer)
    else $error("acknowledge not wait then done");
  a_access_span: assert property (s_start |-> s_span)
    else $error("select not held exactly two cycles");
  a_ack_holds: assert property ((!sel_n && ack_done) |=> (sel_n || ack_done))
    else $error("acknowledge dropped while selected");
  a_read_drives: assert property (($fell(sel_n) && is_read) |=> d_dev_oe)
    else $error("device silent in read");
  a_write_drives: assert property (($fell(sel_n) && !is_read) |-> (d_host_oe && !d_dev_oe) [*2])
    else $error("host data not driven in write");
endmodule : hpev_monitor
`default_nettype wire

// ===== verification/hpev_tb.sv
/*
  Self-checking bench: one device and one host per strap style.
  Assumes 25 MHz clock; style 0 pins watched by the monitor.
*/
`timescale 1ns/100ps
`default_nettype none
module hpev_tb import hpev_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic bip = 1'b0, crc = 1'b0, fp = 1'b0, tick = 1'b0, rck = 1'b1, wck = 1'b1;
  logic oqa = 1'b0, phy = 1'b1, avl = 1'b0, soc = 1'b0, enb_n = 1'b1;
  logic rxv = 1'b0, tdn = 1'b0, tac = 1'b0, frame_on = 1'b1;
  logic req = 1'b0, lnk = 1'b0, lrv = 1'b0;
  logic [1:0] oqc = 2'h0;
  logic [6:0] oql = 7'h00;
  logic [7:0] rxb = 8'h00;
  logic [3:0] tcnt = 4'h0;
  logic [7:0] rdd [2];
  logic [7:0] txd [2];
  logic rdv [2], irq [2], txr [2];
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [7:0] RST_A [9] = '{ADDR_STATUS_A, ADDR_ENABLE_A, ADDR_STATUS_B,
    ADDR_ENABLE_B, ADDR_CELL_CTRL, ADDR_PORT_CFG, ADDR_GRANT_TIMEOUT, ADDR_CBR_LEN, 8'h20};
  localparam logic [7:0] RW_A [5] = '{ADDR_ENABLE_A, ADDR_ENABLE_B, ADDR_PORT_CFG,
    ADDR_GRANT_TIMEOUT, ADDR_CBR_LEN};
  // split, class, level before arrival, overflow expected
  localparam logic [10:0] OQ [9] = '{{1'b0, OQ_CLASS_ABR, 7'h7A, 1'b0},
    {1'b0, OQ_CLASS_ABR, 7'h7B, 1'b1}, {1'b1, OQ_CLASS_ABR, 7'h1F, 1'b0},
    {1'b1, OQ_CLASS_ABR, 7'h20, 1'b1}, {1'b1, OQ_CLASS_CTL, 7'h02, 1'b1},
    {1'b1, OQ_CLASS_CBR, 7'h0F, 1'b0}, {1'b1, OQ_CLASS_CBR, 7'h10, 1'b1},
    {1'b1, OQ_CLASS_VBR, 7'h48, 1'b0}, {1'b1, OQ_CLASS_VBR, 7'h49, 1'b1}};
  always #20 clk = ~clk;
  // continuous bus frames; frame_on low starves the frame-loss counter
  always @(posedge clk) begin
    tick <= 1'b1;
    tcnt <= tcnt + 4'h1;
    fp <= frame_on && (tcnt == 4'hF);
  end
  for (genvar g = 0; g < 2; g++) begin : g_end
    hpev_if hpev_if_i ();
    hpev_device hpev_device_i (.clk(clk), .srst(srst), .port(hpev_if_i.dev),
      .bip_err(bip), .hdr_crc_err(crc), .bus_frame_pulse(fp), .bus_cycle_tick(tick),
      .bus_rdclk_ok(rck), .bus_wrclk_ok(wck), .bus_req(req), .bus_grant(1'b0),
      .oq_arrive(oqa), .oq_class(oqc), .oq_level(oql), .phy_side_select(phy),
      .link_mode(lnk), .inlet_cell_avail(avl), .inlet_cell_start(soc),
      .inlet_xfer_enable_n(enb_n), .link_rx_valid(lrv), .rx_byte_valid(rxv),
      .rx_byte(rxb), .tx_cell_send_request(txr[g]), .tx_rd_addr(6'h00),
      .tx_rd_data(txd[g]), .tx_done(tdn), .tx_accepted(tac), .online(), .split_queue());
    hpev_host #(.HOST_STYLE(g == 1)) hpev_host_i (.clk(clk), .srst(srst),
      .port(hpev_if_i.host), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_busy(), .rd_data(rdd[g]), .rd_valid(rdv[g]), .irq(irq[g]));
    if (g == 0) begin : g_mon
      hpev_monitor hpev_monitor_i (.clk(clk), .srst(srst),
        .host_style_strap(hpev_if_i.host_style_strap), .sel_n(hpev_if_i.sel_n),
        .rd_n(hpev_if_i.rd_n), .wr_n(hpev_if_i.wr_n), .d_host_oe(hpev_if_i.d_host_oe),
        .d_dev_oe(hpev_if_i.d_dev_oe), .ack_pin(hpev_if_i.ack_pin));
    end
  end
  task automatic final_report();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : reg_wr
  // evt pulses a parity event onto the edge that takes the read
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input logic evt = 1'b0);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_addr <= a;
    @(posedge clk);
    cmd_rd <= 1'b0;
    bip <= evt;
    @(posedge clk);
    bip <= 1'b0;
    @(posedge clk);
    #1;
    for (int g = 0; g < 2; g++) begin
      check("rd_valid", {7'h00, rdv[g]}, 8'h01);
      check("rd_data", rdd[g], exp);
    end
    @(posedge clk);
  endtask : reg_rd
  task automatic chk_irq(input logic exp);
    repeat (4) @(posedge clk);
    #1;
    check("irq0", {7'h00, irq[0]}, {7'h00, exp});
    check("irq1", {7'h00, irq[1]}, {7'h00, exp});
    check("irq_pin0", {7'h00, g_end[0].hpev_if_i.irq_pin}, {7'h00, exp});
    check("irq_pin1", {7'h00, g_end[1].hpev_if_i.irq_pin}, {7'h00, !exp});
  endtask : chk_irq
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    foreach (RST_A[i]) reg_rd(RST_A[i], (i == 4) ? CELL_CTRL_RESET : REG_RESET);
    foreach (RW_A[i]) begin
      reg_wr(RW_A[i], 8'hA5 ^ 8'(i));
      reg_rd(RW_A[i], 8'hA5 ^ 8'(i));
    end
    chk_irq(1'b0);
    foreach (RW_A[i]) reg_wr(RW_A[i], 8'h00);
    reg_wr(ADDR_TX_BUF, 8'h3C);
    reg_rd(ADDR_TX_BUF, 8'h3C);
    check("tx_rd_data", txd[1], 8'h3C);
    check("tx_rd_data0", txd[0], 8'h3C);
    reg_wr(ADDR_ENABLE_A, 8'h40);
    for (int k = 0; k < 2; k++) begin
      reg_wr(ADDR_CELL_CTRL, 8'h42);
      #1 check("send_req", {7'h00, txr[0]}, 8'h01);
      @(posedge clk);
      tdn <= 1'b1;
      tac <= (k == 0);
      @(posedge clk) tdn <= 1'b0;
      chk_irq(k == 0);
      check("send_req", {7'h00, txr[1]}, 8'h00);
      reg_rd(ADDR_STATUS_A, (k == 0) ? 8'h40 : 8'h80);
      reg_rd(ADDR_STATUS_B, 8'h08);
      reg_rd(ADDR_STATUS_A, 8'h00);
      reg_rd(ADDR_CELL_CTRL, 8'h40);
    end
    reg_rd(ADDR_STATUS_A, 8'h00, 1'b1);
    reg_rd(ADDR_STATUS_A, 8'h20);
    reg_rd(ADDR_STATUS_A, 8'h00);
    @(posedge clk) crc <= 1'b1;
    @(posedge clk) crc <= 1'b0;
    reg_rd(ADDR_STATUS_B, 8'h80);
    reg_wr(ADDR_ENABLE_A, 8'h08);
    @(posedge clk) rck <= 1'b0;
    chk_irq(1'b1);
    reg_rd(ADDR_STATUS_A, 8'h08);
    reg_rd(ADDR_STATUS_A, 8'h08);
    reg_wr(ADDR_ENABLE_A, 8'h00);
    chk_irq(1'b0);
    @(posedge clk) wck <= 1'b0;
    @(posedge clk) rck <= 1'b1;
    reg_rd(ADDR_STATUS_A, 8'h1C);
    @(posedge clk) wck <= 1'b1;
    // flags kept by the last read stay latched until this one
    reg_rd(ADDR_STATUS_A, 8'h14);
    frame_on <= 1'b0;
    repeat (100) @(posedge clk);
    frame_on <= 1'b1;
    repeat (40) @(posedge clk);
    reg_rd(ADDR_STATUS_A, 8'h10);
    reg_rd(ADDR_STATUS_A, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      avl <= 1'b1;
      soc <= (k == 0);
      @(posedge clk);
      avl <= 1'b0;
      soc <= 1'b0;
      reg_rd(ADDR_STATUS_B, (k == 0) ? 8'h00 : 8'h10);
    end
    @(posedge clk);
    phy <= 1'b0;
    soc <= 1'b1;
    enb_n <= 1'b0;
    @(posedge clk);
    soc <= 1'b0;
    enb_n <= 1'b1;
    reg_rd(ADDR_STATUS_B, 8'h10);
    // hardware reset with all clocks present, as after a clock loss
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    reg_rd(ADDR_CELL_CTRL, CELL_CTRL_RESET);
    reg_wr(ADDR_CBR_LEN, 8'h10);
    foreach (OQ[i]) begin
      reg_wr(ADDR_PORT_CFG, {5'h00, OQ[i][10], 2'h0});
      @(posedge clk);
      oqa <= 1'b1;
      oqc <= OQ[i][9:8];
      oql <= OQ[i][7:1];
      @(posedge clk) oqa <= 1'b0;
      reg_rd(ADDR_STATUS_B, {7'h00, OQ[i][0]});
    end
    // link valid dropped mid cell, and a request left ungranted two frames
    reg_wr(ADDR_GRANT_TIMEOUT, 8'h02);
    req <= 1'b1;
    lnk <= 1'b1;
    lrv <= 1'b1;
    repeat (3) @(posedge clk);
    lrv <= 1'b0;
    @(posedge clk) lnk <= 1'b0;
    repeat (36) @(posedge clk);
    req <= 1'b0;
    reg_rd(ADDR_STATUS_B, 8'h14);
    reg_wr(ADDR_ENABLE_B, 8'h20);
    for (int c = 0; c < 5; c++) begin
      for (int k = 0; k < 52; k++) begin
        @(posedge clk);
        rxv <= 1'b1;
        rxb <= (k == 0) ? 8'hC0 + 8'(c) : 8'(k);
      end
      @(posedge clk) rxv <= 1'b0;
    end
    chk_irq(1'b1);
    reg_rd(ADDR_STATUS_B, 8'h60);
    reg_rd(ADDR_STATUS_B, 8'h20);
    reg_rd(ADDR_RX_WIN, 8'hC0);
    reg_rd(ADDR_RX_WIN_END, 8'h33);
    for (int c = 1; c < 5; c++) begin
      reg_wr(ADDR_CELL_CTRL, 8'h41);
      reg_rd(ADDR_STATUS_B, (c < 4) ? 8'h20 : 8'h00);
      if (c < 4) reg_rd(ADDR_RX_WIN, 8'hC0 + 8'(c));
    end
    reg_rd(ADDR_CELL_CTRL, 8'h40);
    chk_irq(1'b0);
    final_report();
  end
endmodule : hpev_tb
`default_nettype wire
